// [lsc_regs.vh]
// Constants for the layer-setting configuration block
`ifndef LSC_REGS_VH
`define LSC_REGS_VH
// ============================================================
// Object dictionary
`define LSC_RATE_SET_INDEX 16'h2400
`define LSC_RATE_SET_RESET 8'hff
// ============================================================
// Frame identifiers
`define LSC_ID_MASTER 11'h7e5
`define LSC_ID_SLAVE 11'h7e4
// ============================================================
// Node identifier values
`define LSC_NODE_UNCONF 8'hff
`define LSC_NODE_MIN 8'h01
`define LSC_NODE_MAX 8'h7f
// ============================================================
// Rate indices
`define LSC_RATE_AUTO 8'hff
`define LSC_RATE_MAX_IDX 8'h04
`define LSC_RATE_MAX_IDX3 3'h4
// ============================================================
// Automatic detection: frames per candidate, total frame budget
`define LSC_TRIES_PER_RATE 2'h3
`define LSC_FRAME_BUDGET 5'h18
// ============================================================
// Command specifiers
`define LSC_CS_SWITCH_GLOBAL 8'h04
`define LSC_CS_CFG_NODE 8'h11
`define LSC_CS_CFG_RATE 8'h13
`define LSC_CS_STORE 8'h17
`define LSC_CS_SEL_VENDOR 8'h40
`define LSC_CS_SEL_PRODUCT 8'h41
`define LSC_CS_SEL_REVISION 8'h42
`define LSC_CS_SEL_SERIAL 8'h43
`define LSC_CS_SEL_ANSWER 8'h44
`define LSC_CS_ASK_VENDOR 8'h5a
`define LSC_CS_ASK_PRODUCT 8'h5b
`define LSC_CS_ASK_REVISION 8'h5c
`define LSC_CS_ASK_SERIAL 8'h5d
`define LSC_CS_ASK_NODE 8'h5e
// ============================================================
// Error codes in answers
`define LSC_ERR_NONE 8'h00
`define LSC_ERR_RANGE 8'h01
`endif

// [lsc_rate_detect.v]
// Automatic bus rate detection by trial over the rate candidates
`timescale 1ns/100ps
`include "lsc_regs.vh"
module lsc_rate_detect
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire enable,
  // Frame results at the current trial rate
  input wire frame_ok,
  input wire frame_err,
  // Result
  output reg [2:0] trial_idx,
  output reg locked
);

  reg [1:0] tries;
  reg [4:0] frames;

  // ============================================================
  // Candidate stepping
  function [2:0] next_idx;
    input [2:0] idx;
    begin
      if (idx >= `LSC_RATE_MAX_IDX3)
        next_idx = 3'h0;
      else
        next_idx = idx + 3'h1;
    end
  endfunction

  // Lock on the first clean frame; a rate that fails three times is dropped
  always @(posedge clk)
  begin
    if (!rst_n || !enable)
    begin
      trial_idx <= 3'h0;
      locked <= 1'b0;
      tries <= 2'h0;
      frames <= 5'h00;
    end
    else if (!locked)
    begin
      if (frame_ok)
        locked <= 1'b1;
      else if (frame_err)
      begin
        // Budget spent without a match: start the sweep again
        if (frames == `LSC_FRAME_BUDGET - 5'h01)
        begin
          frames <= 5'h00;
          tries <= 2'h0;
          trial_idx <= 3'h0;
        end
        else
        begin
          frames <= frames + 5'h01;
          if (tries == `LSC_TRIES_PER_RATE - 2'h1)
          begin
            tries <= 2'h0;
            trial_idx <= next_idx(trial_idx);
          end
          else
            tries <= tries + 2'h1;
        end
      end
    end
  end

endmodule // lsc_rate_detect

// [lsc_layer_setting.v]
// Layer-setting node logic: mode switching, node number, bit rate, storage
`timescale 1ns/100ps
`include "lsc_regs.vh"
module lsc_layer_setting
#(
  parameter [31:0] VENDOR_CODE = 32'h0000_0a5c, // Arbitrary value
  parameter [31:0] PRODUCT_CODE = 32'h0000_1234, // Arbitrary value
  parameter [31:0] REVISION_CODE = 32'h0001_0000, // Arbitrary value
  parameter [31:0] SERIAL_CODE = 32'h0000_0001 // Arbitrary value
)
(
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Received frames from the CAN controller
  input wire RX_VALID,
  input wire [10:0] RX_ID,
  input wire [63:0] RX_DATA,
  input wire RX_FRAME_OK,
  input wire RX_FRAME_ERR,
  // Answer frames to the CAN controller
  output reg TX_VALID,
  output wire [10:0] TX_ID,
  output reg [63:0] TX_DATA,
  input wire TX_READY,
  // Non-volatile storage
  input wire [7:0] NV_NODE_ID,
  input wire [7:0] NV_RATE,
  output reg NV_WRITE,
  output reg [7:0] NV_WR_NODE_ID,
  output reg [7:0] NV_WR_RATE,
  // Object dictionary read port
  input wire OD_RD,
  input wire [15:0] OD_INDEX,
  output reg OD_ACK,
  output reg [7:0] OD_RDATA,
  // Node state
  output reg [7:0] NODE_ID,
  output reg CONFIG_MODE,
  output wire INIT_HOLD,
  output reg NMT_INIT_GO,
  output wire [2:0] BIT_RATE_SEL,
  output wire RATE_FOUND,
  output wire FRAME_ACCEPT
);

  // Selective addressing steps
  localparam [1:0] SEL_IDLE = 2'h0;
  localparam [1:0] SEL_VENDOR = 2'h1;
  localparam [1:0] SEL_PRODUCT = 2'h2;
  localparam [1:0] SEL_REVISION = 2'h3;

  reg [7:0] rate_setting;
  reg [1:0] sel_step;
  reg loaded;
  reg [7:0] pend_node;
  reg [7:0] pend_rate;
  reg [7:0] next_node;
  reg [7:0] next_rate;
  reg next_cfg;
  reg [1:0] next_sel;
  reg next_tx;
  reg [63:0] next_data;
  reg next_store;
  reg next_assigned;
  wire auto_sel;
  wire [2:0] trial_idx;
  wire locked;
  wire [7:0] cmd;
  wire [31:0] arg;
  wire take;

  // ============================================================
  // Helpers
  // Little-endian word in bytes 1 to 4
  function [31:0] frame_word;
    input [63:0] d;
    begin
      frame_word = d[39:8];
    end
  endfunction

  // Answer frame: command byte then a 32-bit word
  function [63:0] answer;
    input [7:0] cs;
    input [31:0] w;
    begin
      answer = {24'h000000, w, cs};
    end
  endfunction

  function node_valid;
    input [7:0] n;
    begin
      node_valid = (n >= `LSC_NODE_MIN) && (n <= `LSC_NODE_MAX);
    end
  endfunction

  // ============================================================
  // Rate selection
  assign auto_sel = (rate_setting == `LSC_RATE_AUTO);

  lsc_rate_detect u_detect
  (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .enable(auto_sel),
    .frame_ok(RX_FRAME_OK),
    .frame_err(RX_FRAME_ERR),
    .trial_idx(trial_idx),
    .locked(locked)
  );

  // Fixed index drives the controller directly, else the trial rate
  assign BIT_RATE_SEL = auto_sel ? trial_idx : rate_setting[2:0];
  assign RATE_FOUND = !auto_sel || locked;
  // Frames stay unprocessed until the rate is known, costing boot time
  assign FRAME_ACCEPT = RATE_FOUND && loaded;
  assign INIT_HOLD = (NODE_ID == `LSC_NODE_UNCONF);
  assign TX_ID = `LSC_ID_SLAVE;

  assign cmd = RX_DATA[7:0];
  assign arg = frame_word(RX_DATA);
  // A frame is dropped while an answer waits, so no answer is ever lost
  assign take = RX_VALID && FRAME_ACCEPT && (RX_ID == `LSC_ID_MASTER) && !TX_VALID;

  // ============================================================
  // Command decode
  always @*
  begin
    next_node = pend_node;
    next_rate = pend_rate;
    next_cfg = CONFIG_MODE;
    next_sel = sel_step;
    next_tx = 1'b0;
    next_data = 64'h0000000000000000;
    next_store = 1'b0;
    next_assigned = 1'b0;
    if (take)
    begin
      case (cmd)
        `LSC_CS_SWITCH_GLOBAL:
        begin
          next_cfg = RX_DATA[8];
          next_sel = SEL_IDLE;
          // Leaving configuration commits the settings
          if (CONFIG_MODE && !RX_DATA[8])
            next_store = 1'b1;
        end
        `LSC_CS_SEL_VENDOR:
          next_sel = (arg == VENDOR_CODE) ? SEL_VENDOR : SEL_IDLE;
        `LSC_CS_SEL_PRODUCT:
          next_sel = (sel_step == SEL_VENDOR && arg == PRODUCT_CODE) ?
            SEL_PRODUCT : SEL_IDLE;
        `LSC_CS_SEL_REVISION:
          // Any revision value passes, zero included
          next_sel = (sel_step == SEL_PRODUCT) ? SEL_REVISION : SEL_IDLE;
        `LSC_CS_SEL_SERIAL:
        begin
          next_sel = SEL_IDLE;
          if (sel_step == SEL_REVISION && arg == SERIAL_CODE)
          begin
            next_cfg = 1'b1;
            next_tx = 1'b1;
            next_data = answer(`LSC_CS_SEL_ANSWER, 32'h00000000);
          end
        end
        `LSC_CS_CFG_NODE:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            if (node_valid(RX_DATA[15:8]))
            begin
              next_node = RX_DATA[15:8];
              next_data = answer(cmd, {24'h000000, `LSC_ERR_NONE});
            end
            else
              next_data = answer(cmd, {24'h000000, `LSC_ERR_RANGE});
          end
        `LSC_CS_CFG_RATE:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            // Byte 1 selects the table, byte 2 the index
            if (RX_DATA[15:8] == 8'h00 &&
              (RX_DATA[23:16] <= `LSC_RATE_MAX_IDX || RX_DATA[23:16] == `LSC_RATE_AUTO))
            begin
              next_rate = RX_DATA[23:16];
              next_data = answer(cmd, {24'h000000, `LSC_ERR_NONE});
            end
            else
              next_data = answer(cmd, {24'h000000, `LSC_ERR_RANGE});
          end
        `LSC_CS_STORE:
          if (CONFIG_MODE)
          begin
            next_store = 1'b1;
            next_tx = 1'b1;
            next_data = answer(cmd, {24'h000000, `LSC_ERR_NONE});
          end
        `LSC_CS_ASK_VENDOR:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            next_data = answer(cmd, VENDOR_CODE);
          end
        `LSC_CS_ASK_PRODUCT:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            next_data = answer(cmd, PRODUCT_CODE);
          end
        `LSC_CS_ASK_REVISION:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            next_data = answer(cmd, REVISION_CODE);
          end
        `LSC_CS_ASK_SERIAL:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            next_data = answer(cmd, SERIAL_CODE);
          end
        `LSC_CS_ASK_NODE:
          if (CONFIG_MODE)
          begin
            next_tx = 1'b1;
            next_data = {48'h000000000000, NODE_ID, cmd};
          end
        default:
          next_tx = 1'b0;
      endcase
    end
    // An unconfigured node takes a valid number at once
    if (INIT_HOLD && node_valid(next_node) && next_node != pend_node)
      next_assigned = 1'b1;
  end

  // ============================================================
  // State registers
  // Stored values are caught on the first edge after reset release
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      loaded <= 1'b0;
      NODE_ID <= `LSC_NODE_UNCONF;
      rate_setting <= `LSC_RATE_SET_RESET;
      pend_node <= `LSC_NODE_UNCONF;
      pend_rate <= `LSC_RATE_SET_RESET;
      CONFIG_MODE <= 1'b0;
      sel_step <= SEL_IDLE;
      NMT_INIT_GO <= 1'b0;
    end
    else if (!loaded)
    begin
      loaded <= 1'b1;
      // Garbage in storage counts as unconfigured
      NODE_ID <= node_valid(NV_NODE_ID) ? NV_NODE_ID : `LSC_NODE_UNCONF;
      pend_node <= node_valid(NV_NODE_ID) ? NV_NODE_ID : `LSC_NODE_UNCONF;
      rate_setting <= (NV_RATE <= `LSC_RATE_MAX_IDX) ? NV_RATE : `LSC_RATE_AUTO;
      pend_rate <= (NV_RATE <= `LSC_RATE_MAX_IDX) ? NV_RATE : `LSC_RATE_AUTO;
    end
    else
    begin
      pend_node <= next_node;
      pend_rate <= next_rate;
      CONFIG_MODE <= next_cfg;
      sel_step <= next_sel;
      NMT_INIT_GO <= next_assigned;
      if (next_assigned)
        NODE_ID <= next_node;
      // Rate changes only on commit, so the bus is not lost mid-dialogue
      if (next_store)
      begin
        NODE_ID <= next_node;
        rate_setting <= next_rate;
      end
    end
  end

  // ============================================================
  // Answer holding: stands until the controller takes it
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      TX_VALID <= 1'b0;
      TX_DATA <= 64'h0000000000000000;
    end
    else if (next_tx)
    begin
      TX_VALID <= 1'b1;
      TX_DATA <= next_data;
    end
    else if (TX_READY)
      TX_VALID <= 1'b0;
  end

  // ============================================================
  // Storage write: one pulse per commit or first assignment
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      NV_WRITE <= 1'b0;
      NV_WR_NODE_ID <= `LSC_NODE_UNCONF;
      NV_WR_RATE <= `LSC_RATE_SET_RESET;
    end
    else
    begin
      NV_WRITE <= next_store || next_assigned;
      if (next_store || next_assigned)
      begin
        NV_WR_NODE_ID <= next_node;
        NV_WR_RATE <= next_store ? next_rate : rate_setting;
      end
    end
  end

  // ============================================================
  // Read-only rate entry; other indices answer zero
  always @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      OD_ACK <= 1'b0;
      OD_RDATA <= 8'h00;
    end
    else
    begin
      OD_ACK <= OD_RD;
      if (OD_RD)
        OD_RDATA <= (OD_INDEX == `LSC_RATE_SET_INDEX) ? rate_setting : 8'h00;
    end
  end

endmodule // lsc_layer_setting

// [lsc_layer_setting_properties.sv]
// Port checker for the layer-setting block
`timescale 1ns/100ps
module lsc_layer_setting_properties
(
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Requests
  input wire RX_VALID,
  input wire TX_READY,
  input wire OD_RD,
  input wire [15:0] OD_INDEX,
  // Answers and state
  input wire TX_VALID,
  input wire [10:0] TX_ID,
  input wire [63:0] TX_DATA,
  input wire OD_ACK,
  input wire [7:0] OD_RDATA,
  input wire [7:0] NODE_ID,
  input wire INIT_HOLD,
  input wire NMT_INIT_GO,
  input wire [2:0] BIT_RATE_SEL,
  input wire RATE_FOUND,
  input wire FRAME_ACCEPT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // ========
  // Frame side
  a_answer_id: assert property (TX_ID == 11'h7e4) else $error("answer id");
  // An answer must not move until the controller takes it
  a_answer_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("answer dropped");
  a_no_early_rx: assert property (!RATE_FOUND |-> !FRAME_ACCEPT) else $error("early rx");
  a_refused_quiet: assert property (RX_VALID && !FRAME_ACCEPT && !TX_VALID |=> !TX_VALID)
    else $error("frame answered");
  // ========
  // Node and rate state
  a_hold_node: assert property (INIT_HOLD == (NODE_ID == 8'hff)) else $error("hold");
  a_node_range: assert property (NODE_ID == 8'hff || (NODE_ID != 8'h00 && NODE_ID <= 8'h7f))
    else $error("node range");
  a_go_once: assert property (NMT_INIT_GO |-> $past(INIT_HOLD) && !INIT_HOLD)
    else $error("init go");
  a_rate_index: assert property (BIT_RATE_SEL <= 3'h4) else $error("rate index");
  // ========
  // Dictionary read
  a_od_answer: assert property (OD_RD |=> OD_ACK ##1 !OD_ACK) else $error("od ack");
  a_od_other: assert property (OD_RD && OD_INDEX != 16'h2400 |=> OD_RDATA == 8'h00)
    else $error("od data");
endmodule // lsc_layer_setting_properties

// [lsc_can_side.sv]
// Controller-side model taking answers after a random stall
`timescale 1ns/100ps
module lsc_can_side
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Answer handshake
  input wire tx_valid,
  input wire [63:0] tx_data,
  output reg tx_ready = 1'b0,
  // Taken answer
  output reg got = 1'b0,
  output reg [63:0] got_data = 64'h0
);
  reg [1:0] stall = 2'h0;
  // Stall of zero to three cycles, so a slow taker is covered too
  always @(posedge clk)
  begin
    got <= 1'b0;
    if (!rst_n)
      tx_ready <= 1'b0;
    else if (tx_valid && tx_ready)
    begin
      tx_ready <= 1'b0;
      got <= 1'b1;
      got_data <= tx_data;
      stall <= 2'($urandom % 4);
    end
    else if (tx_valid && stall == 2'h0)
      tx_ready <= 1'b1;
    else if (tx_valid)
      stall <= stall - 2'h1;
  end
endmodule // lsc_can_side

// [tb_lsc_layer_setting.sv]
// Testbench of the layer-setting block
`timescale 1ns/100ps
module tb_lsc_layer_setting;
  localparam [31:0] VC = 32'h0000_0b17; // Arbitrary value
  localparam [31:0] PC = 32'h0000_0c2e; // Arbitrary value
  localparam [31:0] RC = 32'h0002_0003; // Arbitrary value
  localparam [31:0] SC = 32'h0000_77a1; // Arbitrary value
  reg CLK_SYS = 1'b0;
  reg RST_N = 1'b0;
  reg RX_VALID = 1'b0, RX_FRAME_OK = 1'b0, RX_FRAME_ERR = 1'b0, OD_RD = 1'b0;
  reg [10:0] RX_ID = 11'h0;
  reg [63:0] RX_DATA = 64'h0;
  reg [15:0] OD_INDEX = 16'h0;
  reg [7:0] NV_NODE_ID = 8'hff, NV_RATE = 8'hff;
  wire TX_VALID, TX_READY, NV_WRITE, OD_ACK, CONFIG_MODE, INIT_HOLD, NMT_INIT_GO;
  wire RATE_FOUND, FRAME_ACCEPT, got;
  wire [10:0] TX_ID;
  wire [63:0] TX_DATA, ans;
  wire [7:0] NV_WR_NODE_ID, NV_WR_RATE, OD_RDATA, NODE_ID;
  wire [2:0] BIT_RATE_SEL;
  reg go_seen = 1'b0;
  reg [39:0] q[$];
  reg [7:0] r;
  integer bad_count = 0, samples_checked = 0, i, nv_writes = 0;
  // ========
  // Clock and instances
  always #50 CLK_SYS = ~CLK_SYS;
  lsc_layer_setting #(.VENDOR_CODE(VC), .PRODUCT_CODE(PC), .REVISION_CODE(RC),
    .SERIAL_CODE(SC)) dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .RX_VALID(RX_VALID),
    .RX_ID(RX_ID), .RX_DATA(RX_DATA), .RX_FRAME_OK(RX_FRAME_OK), .RX_FRAME_ERR(RX_FRAME_ERR),
    .TX_VALID(TX_VALID), .TX_ID(TX_ID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
    .NV_NODE_ID(NV_NODE_ID), .NV_RATE(NV_RATE), .NV_WRITE(NV_WRITE),
    .NV_WR_NODE_ID(NV_WR_NODE_ID), .NV_WR_RATE(NV_WR_RATE), .OD_RD(OD_RD),
    .OD_INDEX(OD_INDEX), .OD_ACK(OD_ACK), .OD_RDATA(OD_RDATA), .NODE_ID(NODE_ID),
    .CONFIG_MODE(CONFIG_MODE), .INIT_HOLD(INIT_HOLD), .NMT_INIT_GO(NMT_INIT_GO),
    .BIT_RATE_SEL(BIT_RATE_SEL), .RATE_FOUND(RATE_FOUND), .FRAME_ACCEPT(FRAME_ACCEPT));
  lsc_can_side u_side (.clk(CLK_SYS), .rst_n(RST_N), .tx_valid(TX_VALID),
    .tx_data(TX_DATA), .tx_ready(TX_READY), .got(got), .got_data(ans));
  // ========
  // Tasks
  task chk(input [39:0] a, input [39:0] e);
  begin
    samples_checked = samples_checked + 1;
    if (a !== e)
    begin
      bad_count = bad_count + 1;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  end
  endtask
  // Frame on the request id, then wait out any answer
  task send(input [7:0] cs, input [31:0] w);
    integer k;
  begin
    @(posedge CLK_SYS);
    RX_VALID <= 1'b1;
    RX_ID <= 11'h7e5;
    RX_DATA <= {24'h0, w, cs};
    @(posedge CLK_SYS);
    RX_VALID <= 1'b0;
    RX_DATA <= ~RX_DATA;
    repeat (2) @(posedge CLK_SYS);
    for (k = 0; k < 20 && TX_VALID === 1'b1; k = k + 1)
      @(posedge CLK_SYS);
    #1;
  end
  endtask
  task xsend(input [7:0] cs, input [31:0] w, input [39:0] e);
  begin
    q.push_back(e);
    send(cs, w);
  end
  endtask
  task od(input [15:0] idx, input [7:0] e);
  begin
    @(posedge CLK_SYS);
    OD_RD <= 1'b1;
    OD_INDEX <= idx;
    @(posedge CLK_SYS);
    OD_RD <= 1'b0;
    OD_INDEX <= ~idx;
    #1;
    chk(OD_ACK, 1'b1);
    chk(OD_RDATA, e);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // ========
  // Answer monitor, oldest note first
  always @(posedge CLK_SYS)
  begin
    if (NMT_INIT_GO === 1'b1)
      go_seen <= 1'b1;
    // Every storage write pulse is counted once
    if (NV_WRITE === 1'b1)
      nv_writes = nv_writes + 1;
    if (got === 1'b1)
    begin
      chk(q.size() > 0, 1'b1);
      if (q.size() > 0)
        chk(ans[39:0], q.pop_front());
    end
  end
  // Hang guard well beyond the few hundred cycles of the run
  initial
  begin
    #800000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  // ========
  // Main sequence
  initial
  begin
    r = 8'($urandom(14296));
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(NODE_ID, 8'hff);
    chk(INIT_HOLD, 1'b1);
    od(16'h2400, 8'hff);
    send(8'h04, 32'h1);
    chk(CONFIG_MODE, 1'b0);
    for (i = 1; i <= 24; i = i + 1)
    begin
      @(posedge CLK_SYS);
      RX_FRAME_ERR <= 1'b1;
      @(posedge CLK_SYS);
      RX_FRAME_ERR <= 1'b0;
      #1;
      if (i % 3 == 0)
        chk(BIT_RATE_SEL, (i == 24) ? 0 : (i / 3) % 5);
    end
    @(posedge CLK_SYS);
    RX_FRAME_OK <= 1'b1;
    @(posedge CLK_SYS);
    RX_FRAME_OK <= 1'b0;
    #1;
    chk(RATE_FOUND, 1'b1);
    send(8'h04, 32'h1);
    chk(CONFIG_MODE, 1'b1);
    xsend(8'h11, 32'h80, {32'h1, 8'h11});
    chk(NODE_ID, 8'hff);
    xsend(8'h11, 32'h5, {32'h0, 8'h11});
    chk(NODE_ID, 8'h05);
    chk(go_seen, 1'b1);
    chk(NV_WR_NODE_ID, 8'h05);
    xsend(8'h5a, 32'h0, {VC, 8'h5a});
    xsend(8'h5b, 32'h0, {PC, 8'h5b});
    xsend(8'h5c, 32'h0, {RC, 8'h5c});
    xsend(8'h5d, 32'h0, {SC, 8'h5d});
    xsend(8'h5e, 32'h0, {32'h5, 8'h5e});
    // Inquiry on the answer id must be ignored, no answer at all
    @(posedge CLK_SYS);
    RX_VALID <= 1'b1;
    RX_ID <= 11'h7e4;
    RX_DATA <= {56'h0, 8'h5e};
    @(posedge CLK_SYS);
    RX_VALID <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk(TX_VALID, 1'b0);
    for (i = 0; i < 5; i = i + 1)
    begin
      xsend(8'h13, i << 8, {32'h0, 8'h13});
      xsend(8'h17, 32'h0, {32'h0, 8'h17});
      chk(BIT_RATE_SEL, i);
      chk(NV_WR_RATE, i);
      od(16'h2400, i);
    end
    od(16'h2401, 8'h00);
    send(8'h04, 32'h0);
    chk(CONFIG_MODE, 1'b0);
    send(8'h5e, 32'h0);
    send(8'h40, VC);
    send(8'h41, PC);
    send(8'h42, 32'h0);
    send(8'h43, SC ^ 32'h1);
    chk(CONFIG_MODE, 1'b0);
    send(8'h40, VC);
    send(8'h41, PC);
    send(8'h42, 32'h0);
    xsend(8'h43, SC, {32'h0, 8'h44});
    chk(CONFIG_MODE, 1'b1);
    r = 8'($urandom % 127 + 1);
    xsend(8'h11, {24'h0, r}, {32'h0, 8'h11});
    send(8'h04, 32'h0);
    chk(NODE_ID, r);
    chk(NV_WR_NODE_ID, r);
    // Assign, five stores, two exits from configuration
    chk(nv_writes, 8);
    // Power cycle with the saved values fed back from storage
    @(posedge CLK_SYS);
    NV_NODE_ID <= r;
    NV_RATE <= 8'h04;
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk(NODE_ID, r);
    chk(INIT_HOLD, 1'b0);
    chk(BIT_RATE_SEL, 3'h4);
    chk(RATE_FOUND, 1'b1);
    od(16'h2400, 8'h04);
    repeat (10) @(posedge CLK_SYS);
    chk(q.size(), 0);
    wrap_up;
  end
endmodule // tb_lsc_layer_setting
bind lsc_layer_setting lsc_layer_setting_properties u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .RX_VALID(RX_VALID), .TX_READY(TX_READY), .OD_RD(OD_RD), .OD_INDEX(OD_INDEX),
  .TX_VALID(TX_VALID), .TX_ID(TX_ID), .TX_DATA(TX_DATA), .OD_ACK(OD_ACK),
  .OD_RDATA(OD_RDATA), .NODE_ID(NODE_ID), .INIT_HOLD(INIT_HOLD), .NMT_INIT_GO(NMT_INIT_GO),
  .BIT_RATE_SEL(BIT_RATE_SEL), .RATE_FOUND(RATE_FOUND), .FRAME_ACCEPT(FRAME_ACCEPT));
